// file: design/rivm_regs.vh
`ifndef RIVM_REGS_VH
`define RIVM_REGS_VH
// ==========================================
// address layout
// ==========================================
`define RIVM_ADDR_W        16
`define RIVM_RESET_ADDR    16'h0000
`define RIVM_TABLE_OFFSET  16'h0002
`define RIVM_VEC_STRIDE    2
`define RIVM_BOOT_ADDR_DEF 16'h1C00
// ==========================================
// source counts
// ==========================================
`define RIVM_NUM_SRC       27
`define RIVM_IDX_W         5
`define RIVM_COMPAT_LAST   16'h002A
`define RIVM_NATIVE_LAST   16'h0036
`endif

// file: design/rivm_vector_map.v
`timescale 1ns/10ps
`default_nettype none
`include "rivm_regs.vh"

module rivm_vector_map #(
  parameter [15:0] BOOT_RESET_ADDR = `RIVM_BOOT_ADDR_DEF,
  parameter        NUM_SRC         = `RIVM_NUM_SRC
) (
  input  wire                    i_sys_clk,
  input  wire                    i_reset,
  input  wire                    i_boot_reset_fuse,
  input  wire                    i_compat_layout_fuse,
  input  wire                    i_vector_base_select,
  input  wire [NUM_SRC-1:0]      i_irq_pending,
  input  wire                    i_irq_accept,
  output wire                    o_irq_request,
  output reg  [15:0]             o_reset_addr,
  output reg  [15:0]             o_vector_addr,
  output reg                     o_vector_valid,
  output reg  [4:0]              o_vector_source
);

  // ==========================================
  // fuse capture
  // ==========================================
  reg boot_fuse_reg;
  reg compat_fuse_reg;

  // fuses follow their pins through reset and freeze after it
  always @(posedge i_sys_clk) begin
    if (i_reset) begin
      boot_fuse_reg <= i_boot_reset_fuse;
    end else begin
      boot_fuse_reg <= boot_fuse_reg;
    end
  end

  always @(posedge i_sys_clk) begin
    if (i_reset) begin
      compat_fuse_reg <= i_compat_layout_fuse;
    end else begin
      compat_fuse_reg <= compat_fuse_reg;
    end
  end

  // ==========================================
  // layout constants
  // ==========================================
  // source index: 0..2 ext irqs, 3..4 pin change, 5..8 timer3,
  // 9..16 timer2, timer1 and timer0 events, 17 serial transfer,
  // 18..23 receive, buffer empty and transmit pairs,
  // 24 nv data, 25 comparator, 26 program store
  localparam integer EXT_LAST      = 2;
  localparam integer PIN_FIRST     = 3;
  localparam integer PIN_LAST      = 4;
  localparam integer T3_FIRST      = 5;
  localparam integer T3_LAST       = 8;
  localparam integer SHARED_FIRST  = 9;

  // slot arithmetic
  localparam integer NATIVE_VEC_UP = 2;
  localparam integer COMPAT_VEC_DN = 4;
  localparam integer VEC_STRIDE    = `RIVM_VEC_STRIDE;
  localparam integer TABLE_START   = `RIVM_TABLE_OFFSET;
  localparam [15:0]  COMPAT_LAST   = `RIVM_COMPAT_LAST;
  localparam [15:0]  NATIVE_LAST   = `RIVM_NATIVE_LAST;
  localparam [15:0]  RESET_VECTOR  = `RIVM_RESET_ADDR;

  // ==========================================
  // per-source slot table and priority chain
  // ==========================================
  wire [NUM_SRC-1:0]        src_eligible;
  wire [NUM_SRC:0]          claim_chain;
  wire [(NUM_SRC+1)*16-1:0] slot_chain;
  wire [(NUM_SRC+1)*5-1:0]  idx_chain;
  genvar                    g;

  // chains start empty below index 0
  assign claim_chain[0]   = 1'b0;
  assign slot_chain[15:0] = 16'h0000;
  assign idx_chain[4:0]   = 5'h00;

  generate
    for (g = 0; g < NUM_SRC; g = g + 1) begin : g_src
      // vector numbers count from 1; the reset vector is number 1
      localparam integer NATIVE_VEC  = g + NATIVE_VEC_UP;
      localparam integer COMPAT_VEC  = (g >= SHARED_FIRST) ? (g - COMPAT_VEC_DN) : NATIVE_VEC;
      localparam integer NATIVE_INT  = TABLE_START + VEC_STRIDE * (NATIVE_VEC - 2);
      localparam integer COMPAT_INT  = TABLE_START + VEC_STRIDE * (COMPAT_VEC - 2);
      localparam integer SRC_INT     = g;
      localparam [15:0]  NATIVE_SLOT = NATIVE_INT[15:0];
      localparam [15:0]  COMPAT_SLOT = COMPAT_INT[15:0];
      localparam [4:0]   SRC_IDX     = SRC_INT[4:0];

      localparam         IS_EXT      = (g <= EXT_LAST);
      localparam         IS_PIN      = (g >= PIN_FIRST) && (g <= PIN_LAST);
      localparam         IS_T3       = (g >= T3_FIRST) && (g <= T3_LAST);

      wire        compat_skip;
      wire        use_native;
      wire        eligible;
      wire        grant;
      wire [15:0] slot;
      wire [15:0] slot_term;
      wire [4:0]  idx_term;

      // compat layout has no pin-change or timer3 slots
      assign compat_skip     = (compat_fuse_reg == 1'b0) && (IS_PIN || IS_T3);
      assign use_native      = IS_EXT || compat_fuse_reg;
      assign slot            = use_native ? NATIVE_SLOT : COMPAT_SLOT;
      assign eligible        = i_irq_pending[g] && !compat_skip;
      assign src_eligible[g] = eligible;

      // lowest index claims first
      assign grant                      = eligible && !claim_chain[g];
      assign claim_chain[g+1]           = claim_chain[g] || eligible;
      assign slot_term                  = grant ? slot : 16'h0000;
      assign idx_term                   = grant ? SRC_IDX : 5'h00;
      assign slot_chain[(g+1)*16 +: 16] = slot_chain[g*16 +: 16] | slot_term;
      assign idx_chain[(g+1)*5 +: 5]    = idx_chain[g*5 +: 5] | idx_term;
    end
  endgenerate

  // ==========================================
  // priority result
  // ==========================================
  wire [4:0]  win_idx;
  wire        win_found;
  wire [15:0] slot_addr;

  assign win_found = claim_chain[NUM_SRC];
  assign win_idx   = idx_chain[NUM_SRC*5 +: 5];
  assign slot_addr = slot_chain[NUM_SRC*16 +: 16];

  // ==========================================
  // request to the core
  // ==========================================
  assign o_irq_request = |src_eligible;

  // ==========================================
  // layout bound
  // ==========================================
  wire [15:0] last_slot;
  wire        slot_in_range;

  assign last_slot     = compat_fuse_reg ? NATIVE_LAST : COMPAT_LAST;
  assign slot_in_range = (slot_addr <= last_slot);

  // ==========================================
  // vector base
  // ==========================================
  wire [15:0] base_next;
  wire [15:0] vector_next;

  assign base_next   = i_vector_base_select ? BOOT_RESET_ADDR : RESET_VECTOR;
  assign vector_next = base_next + slot_addr;

  // ==========================================
  // take
  // ==========================================
  wire take;

  assign take = i_irq_accept && win_found && slot_in_range;

  // ==========================================
  // reset address
  // ==========================================
  wire [15:0] reset_next;

  assign reset_next = boot_fuse_reg ? RESET_VECTOR : BOOT_RESET_ADDR;

  always @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_reset_addr <= 16'h0000;
    end else begin
      o_reset_addr <= reset_next;
    end
  end

  // ==========================================
  // answer strobe
  // ==========================================
  always @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_vector_valid <= 1'b0;
    end else begin
      o_vector_valid <= take;
    end
  end

  // ==========================================
  // vector outputs
  // ==========================================
  always @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_vector_addr <= 16'h0000;
    end else if (take) begin
      o_vector_addr <= vector_next;
    end
  end

  always @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_vector_source <= 5'h00;
    end else if (take) begin
      o_vector_source <= win_idx;
    end
  end

endmodule // rivm_vector_map
`default_nettype wire

// file: bench/rivm_vector_map_properties.sv
`timescale 1ns/10ps
`default_nettype none
module rivm_chk #(
  parameter [15:0] BOOT_RESET_ADDR = 16'h1C00,
  parameter        NUM_SRC         = 27
) (
  input wire logic               i_sys_clk,
  input wire logic               i_reset,
  input wire logic               i_boot_reset_fuse,
  input wire logic               i_compat_layout_fuse,
  input wire logic               i_vector_base_select,
  input wire logic [NUM_SRC-1:0] i_irq_pending,
  input wire logic               i_irq_accept,
  input wire logic               o_irq_request,
  input wire logic [15:0]        o_reset_addr,
  input wire logic [15:0]        o_vector_addr,
  input wire logic               o_vector_valid,
  input wire logic [4:0]         o_vector_source
);
  // ==========================================
  // fuse copies and expected slot
  // ==========================================
  logic        boot_cap = 1'b1;
  logic        compat_cap = 1'b1;
  logic [15:0] exp_slot;
  always @(posedge i_sys_clk) begin
    if (i_reset) begin
      boot_cap <= i_boot_reset_fuse;
      compat_cap <= i_compat_layout_fuse;
    end
  end
  // compat shared sources sit six vector numbers lower
  always_comb begin
    if (!compat_cap && o_vector_source >= 5'h09) begin
      exp_slot = {10'h000, o_vector_source, 1'b0} - 16'h000A;
    end else begin
      exp_slot = {10'h000, o_vector_source, 1'b0} + 16'h0002;
    end
  end
  // ==========================================
  // properties
  // ==========================================
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  sequence s_take; i_irq_accept && o_irq_request; endsequence
  sequence s_answer; o_vector_valid; endsequence
  property p_take; s_take |=> s_answer; endproperty
  a_take: assert property(p_take) else $error("no vector");
  property p_idle; !(i_irq_accept && o_irq_request) |=> !o_vector_valid; endproperty
  a_idle: assert property(p_idle) else $error("stray vector");
  property p_hold; !$past(i_reset) && !$past(i_reset, 2) |-> $stable(o_reset_addr); endproperty
  a_hold: assert property(p_hold) else $error("reset addr moved");
  property p_reset_addr;
    !$past(i_reset) |-> o_reset_addr == (boot_cap ? 16'h0000 : BOOT_RESET_ADDR);
  endproperty
  a_reset_addr: assert property(p_reset_addr) else $error("reset addr wrong");
  property p_vec_addr;
    s_answer |-> o_vector_addr == ($past(i_vector_base_select) ? BOOT_RESET_ADDR : 16'h0000) + exp_slot;
  endproperty
  a_vec_addr: assert property(p_vec_addr) else $error("vector addr wrong");
  property p_ext_req; (|i_irq_pending[2:0]) |-> o_irq_request; endproperty
  a_ext_req: assert property(p_ext_req) else $error("ext irq not requested");
endmodule // rivm_chk
bind rivm_vector_map rivm_chk #(
  .BOOT_RESET_ADDR(BOOT_RESET_ADDR),
  .NUM_SRC(NUM_SRC)
) chk (
  .i_sys_clk(i_sys_clk),
  .i_reset(i_reset),
  .i_boot_reset_fuse(i_boot_reset_fuse),
  .i_compat_layout_fuse(i_compat_layout_fuse),
  .i_vector_base_select(i_vector_base_select),
  .i_irq_pending(i_irq_pending),
  .i_irq_accept(i_irq_accept),
  .o_irq_request(o_irq_request),
  .o_reset_addr(o_reset_addr),
  .o_vector_addr(o_vector_addr),
  .o_vector_valid(o_vector_valid),
  .o_vector_source(o_vector_source)
);
`default_nettype wire

// file: bench/rivm_core.sv
`timescale 1ns/10ps
`default_nettype none
module rivm_core (
  input  wire logic i_sys_clk,
  input  wire logic i_irq_request,
  input  wire logic i_enable,
  output var  logic o_accept = 1'b0
);
  // take an interrupt only while one is requested
  always @(posedge i_sys_clk) o_accept <= i_irq_request && i_enable && !o_accept;
endmodule // rivm_core
`default_nettype wire

// file: bench/rivm_vector_map_bench.sv
`timescale 1ns/10ps
`default_nettype none
module reset_irq_vector_map_bench;
  logic i_sys_clk=0, i_reset=1, i_boot_reset_fuse=1, i_compat_layout_fuse=1;
  logic i_vector_base_select=0, i_irq_accept, o_irq_request, o_vector_valid;
  logic [26:0] i_irq_pending=0;
  logic [15:0] o_reset_addr, o_vector_addr;
  logic [4:0]  o_vector_source;
  int n_mismatch=0, checked=0, k;
  always #10 i_sys_clk = ~i_sys_clk;
  rivm_vector_map DUT(.i_sys_clk(i_sys_clk), .i_reset(i_reset),
    .i_boot_reset_fuse(i_boot_reset_fuse), .i_compat_layout_fuse(i_compat_layout_fuse),
    .i_vector_base_select(i_vector_base_select), .i_irq_pending(i_irq_pending),
    .i_irq_accept(i_irq_accept), .o_irq_request(o_irq_request),
    .o_reset_addr(o_reset_addr), .o_vector_addr(o_vector_addr),
    .o_vector_valid(o_vector_valid), .o_vector_source(o_vector_source));
  rivm_core core(.i_sys_clk, .i_irq_request(o_irq_request), .i_enable(1'b1),
    .o_accept(i_irq_accept));
  task chk(string n, logic [15:0] s, e);
    checked++;
    if (s !== e) begin n_mismatch++; $display("ERROR %s exp %h seen %h", n, e, s); end
  endtask
  task finish_test;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task boot(logic b, c);
    @(posedge i_sys_clk) begin i_reset <= 1; i_boot_reset_fuse <= b;
      i_compat_layout_fuse <= c; i_irq_pending <= 0; end
    repeat (3) @(posedge i_sys_clk);
    i_reset <= 0;
    repeat (2) @(negedge i_sys_clk);
  endtask
  task t_vec(logic c, s, logic [26:0] m, logic [15:0] e, logic [4:0] es);
    boot(1, c);
    @(posedge i_sys_clk) begin i_vector_base_select <= s; i_irq_pending <= m; end
    for (k = 0; k < 9 && o_vector_valid !== 1; k++) @(negedge i_sys_clk);
    if (k == 9) begin n_mismatch++; finish_test; end
    chk("vector_addr", o_vector_addr, e);
    chk("vector_source", {11'h000, o_vector_source}, {11'h000, es});
    chk("irq_request", {15'h0000, o_irq_request}, 16'h0001);
  endtask
  initial begin
    boot(1, 1); chk("reset_addr", o_reset_addr, 16'h0000);
    boot(0, 1); chk("reset_addr", o_reset_addr, 16'h1C00);
    t_vec(0, 0, 27'h0000208, 16'h0008, 5'h09);
    t_vec(0, 1, 27'h4000000, 16'h1C2A, 5'h1A);
    t_vec(1, 0, 27'h0000008, 16'h0008, 5'h03);
    t_vec(1, 1, 27'h4000005, 16'h1C02, 5'h00);
    finish_test;
  end
endmodule // reset_irq_vector_map_bench
`default_nettype wire
